/* File: core/e1msc_ais_detect.sv */
module e1msc_ais_detect
	import e1msc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic ce_i,
	e1msc_ais_if.det  port_i
);

	logic [8:0] bit_count;
	logic [1:0] zero_count;
	logic       prev_quiet;
	logic       ais;
	logic       last_bit;
	logic       quiet_now;

	assign last_bit  = bit_count == AIS_WINDOW_LAST;
	// Widened by one bit so that a saturated count plus a final zero cannot wrap to quiet.
	assign quiet_now = ({1'b0, zero_count} + {2'b00, ~port_i.bit_data}) < {1'b0, AIS_ZERO_LIMIT};
	assign port_i.ais = ais;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bit_count  <= '0;
			zero_count <= '0;
			prev_quiet <= 1'b0;
			ais        <= 1'b0;
		end else if (ce_i && port_i.bit_valid) begin
			bit_count <= bit_count + 9'h001;
			if (last_bit) begin
				zero_count <= '0;
				prev_quiet <= quiet_now;
				// The paired criterion trades one extra window of latency for noise immunity.
				if (port_i.two_window)
					ais <= quiet_now && prev_quiet;
				else
					ais <= quiet_now;
			end else if (!port_i.bit_data && zero_count != AIS_ZERO_LIMIT) begin
				zero_count <= zero_count + 2'h1;
			end
		end
	end

endmodule

/* File: core/e1msc_ctrl.sv */
module e1msc_ctrl
	import e1msc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       ce_i,
	input  wire logic       cs_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [4:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	input  wire logic       rx_bit_valid_i,
	input  wire logic       rx_bit_i,
	input  wire logic       basic_sync_i,
	input  wire logic       mf_sync_i,
	input  wire logic       frame_is_fas_i,
	input  wire logic       ts0_bit1_slot_i,
	input  wire logic       framed_bit_i,
	input  wire logic       tx_serial_stream_in_i,
	input  wire logic [3:0] rx_crc_rem_i,
	input  wire logic [3:0] tx_crc_delta_i,
	output logic      [3:0] crc_rem_o,
	output logic            tx_line_bit_o,
	output logic            tx_remote_alarm_o,
	output logic            tx_y_bit_o,
	output logic            ts0_bit1_o,
	output logic            crc4_sync_en_o,
	output logic            auto_interwork_en_o,
	output logic            ais_o,
	output logic            basic_reframe_o,
	output logic            mf_reframe_o
);

	// ****************************************
	// Register file
	// ****************************************
	logic [7:0] ctrl_word [CTRL_WORDS];
	logic       sel_ok;
	logic [3:0] sel_idx;
	logic [7:0] mode;
	logic [7:0] slot0;
	logic       transparent;

	function automatic logic in_page(input logic [4:0] a);
		return a >= CTRL_BASE;
	endfunction

	assign sel_ok      = cs_i && in_page(addr_i);
	assign sel_idx     = addr_i[3:0];
	assign mode        = ctrl_word[MODE_SELECT_CTRL[3:0]];
	assign slot0       = ctrl_word[SLOT_ZERO_CTRL[3:0]];
	assign transparent = slot0[TX_TRANSPARENT_MODE_BIT];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < CTRL_WORDS; i++)
				ctrl_word[i] <= CTRL_RESET;
		end else if (ce_i && sel_ok && wr_i) begin
			ctrl_word[sel_idx] <= wdata_i;
		end
	end

	// Addresses below the page read as zero rather than aliasing.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			rdata_o <= 8'h00;
		else if (ce_i && rd_i)
			rdata_o <= sel_ok ? ctrl_word[sel_idx] : 8'h00;
	end

	// ****************************************
	// Line input synchroniser
	// ****************************************
	logic [1:0] bit_valid_meta;
	logic [1:0] bit_data_meta;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bit_valid_meta <= 2'h0;
			bit_data_meta  <= 2'h0;
		end else if (ce_i) begin
			bit_valid_meta <= {bit_valid_meta[0], rx_bit_valid_i};
			bit_data_meta  <= {bit_data_meta[0], rx_bit_i};
		end
	end

	// ****************************************
	// Alarm indication detection
	// ****************************************
	e1msc_ais_if ais_bus ();

	assign ais_bus.bit_valid  = bit_valid_meta[1];
	assign ais_bus.bit_data   = bit_data_meta[1];
	assign ais_bus.two_window = mode[ALARM_CRITERION_SELECT_BIT];
	assign ais_o              = ais_bus.ais;

	e1msc_ais_detect u_ais (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.ce_i     (ce_i),
		.port_i   (ais_bus.det)
	);

	// ****************************************
	// Transmit overhead selection
	// ****************************************
	logic [7:0] nfas_word;
	logic [7:0] mfas_word;
	logic       next_alarm;
	logic       next_y;
	logic       next_ts0;
	logic       next_line;
	logic [3:0] next_rem;

	assign nfas_word = ctrl_word[NON_FRAME_ALIGN_CTRL[3:0]];
	assign mfas_word = ctrl_word[TX_MULTIFRAME_ALIGN[3:0]];

	always_comb begin
		if (mode[MANUAL_REMOTE_ALARM_BIT])
			next_alarm = nfas_word[TX_REMOTE_ALARM_BIT_BIT];
		else
			next_alarm = basic_sync_i;
		if (mode[MANUAL_Y_BIT_BIT])
			next_y = mfas_word[Y_BIT_POS];
		else
			next_y = ~mf_sync_i;
		// With CRC on, the international bit position is left to the CRC path.
		if (mode[CRC4_SYNC_DISABLE_BIT])
			next_ts0 = frame_is_fas_i ? slot0[INTL_BIT_FAS_BIT]
				: slot0[INTL_BIT_NFAS_BIT];
		else
			next_ts0 = framed_bit_i;
		if (transparent)
			next_line = tx_serial_stream_in_i;
		else if (ts0_bit1_slot_i)
			next_line = next_ts0;
		else
			next_line = framed_bit_i;
		if (transparent && mode[REMAINDER_MODIFY_ENABLE_BIT])
			next_rem = rx_crc_rem_i ^ tx_crc_delta_i;
		else
			next_rem = rx_crc_rem_i;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_remote_alarm_o <= 1'b0;
			tx_y_bit_o        <= 1'b1;
			ts0_bit1_o        <= 1'b0;
			tx_line_bit_o     <= 1'b0;
			crc_rem_o         <= 4'h0;
		end else if (ce_i) begin
			tx_remote_alarm_o <= next_alarm;
			tx_y_bit_o        <= next_y;
			ts0_bit1_o        <= next_ts0;
			tx_line_bit_o     <= next_line;
			crc_rem_o         <= next_rem;
		end
	end

	assign crc4_sync_en_o      = ~mode[CRC4_SYNC_DISABLE_BIT];
	assign auto_interwork_en_o = ~mode[AUTO_INTERWORK_DISABLE_BIT];

	// ****************************************
	// Reframe requests
	// ****************************************
	// The host holds each bit for a frame; only its release starts a search.
	logic prev_basic;
	logic prev_mf;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_basic      <= 1'b0;
			prev_mf         <= 1'b0;
			basic_reframe_o <= 1'b0;
			mf_reframe_o    <= 1'b0;
		end else if (ce_i) begin
			prev_basic      <= mode[BASIC_REFRAME_REQUEST_BIT];
			prev_mf         <= mode[MULTIFRAME_REFRAME_REQUEST_BIT];
			basic_reframe_o <= prev_basic && !mode[BASIC_REFRAME_REQUEST_BIT];
			mf_reframe_o    <= prev_mf && !mode[MULTIFRAME_REFRAME_REQUEST_BIT];
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence basic_fall_s;
		$fell(mode[BASIC_REFRAME_REQUEST_BIT]) && ce_i;
	endsequence

	chk_basic_reframe_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		basic_fall_s ##0 $past(ce_i) |=> ce_i |-> basic_reframe_o)
		else $error("basic reframe pulse missing");
	chk_mf_reframe_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		mf_reframe_o |-> $past(prev_mf) || !$past(ce_i))
		else $error("multiframe reframe without request fall");
	chk_reframe_single_cycle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		basic_reframe_o && ce_i |=> !basic_reframe_o)
		else $error("basic reframe pulse longer than one cycle");
	chk_auto_alarm_sync: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && !mode[MANUAL_REMOTE_ALARM_BIT] |=> tx_remote_alarm_o == $past(basic_sync_i))
		else $error("automatic alarm bit wrong");
	chk_manual_alarm_word: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && mode[MANUAL_REMOTE_ALARM_BIT]
		|=> tx_remote_alarm_o == $past(nfas_word[TX_REMOTE_ALARM_BIT_BIT]))
		else $error("manual alarm bit wrong");
	chk_auto_y_bit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && !mode[MANUAL_Y_BIT_BIT] |=> tx_y_bit_o != $past(mf_sync_i))
		else $error("automatic Y bit wrong");
	chk_manual_y_bit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && mode[MANUAL_Y_BIT_BIT] |=> tx_y_bit_o == $past(mfas_word[Y_BIT_POS]))
		else $error("manual Y bit wrong");
	chk_intl_bits_sent: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && mode[CRC4_SYNC_DISABLE_BIT] && frame_is_fas_i
		|=> ts0_bit1_o == $past(slot0[INTL_BIT_FAS_BIT]))
		else $error("international bit not sent");
	chk_transparent_pass: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && transparent |=> tx_line_bit_o == $past(tx_serial_stream_in_i))
		else $error("transparent data altered");
	chk_interwork_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		auto_interwork_en_o != mode[AUTO_INTERWORK_DISABLE_BIT])
		else $error("interworking enable wrong");

	// ****************************************
	// Register, reframe and transmit path checks
	// ****************************************
	sequence reg_write_s;
		ce_i && cs_i && wr_i && in_page(addr_i);
	endsequence

	sequence mf_fall_s;
		$fell(mode[MULTIFRAME_REFRAME_REQUEST_BIT]) && ce_i;
	endsequence

	chk_write_lands: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		reg_write_s |=> ctrl_word[$past(sel_idx)] == $past(wdata_i))
		else $error("register write lost");
	chk_low_write_ignored: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && cs_i && wr_i && !in_page(addr_i) |=> ctrl_word[$past(sel_idx)] == $past(ctrl_word[sel_idx]))
		else $error("write below page changed a word");
	chk_low_read_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && rd_i && !in_page(addr_i) |=> rdata_o == 8'h00)
		else $error("read below page not zero");
	chk_read_data: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && rd_i && sel_ok |=> rdata_o == $past(ctrl_word[sel_idx]))
		else $error("read data wrong");
	chk_read_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && !rd_i |=> $stable(rdata_o))
		else $error("read data changed without a read");
	chk_mf_reframe_fires: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		mf_fall_s ##0 $past(ce_i) |=> ce_i |-> mf_reframe_o)
		else $error("multiframe reframe pulse missing");
	chk_mf_single_cycle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		mf_reframe_o && ce_i |=> !mf_reframe_o)
		else $error("multiframe reframe pulse longer than one cycle");
	chk_basic_no_early: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && mode[BASIC_REFRAME_REQUEST_BIT] |=> !basic_reframe_o)
		else $error("basic reframe while request held");
	chk_mf_no_early: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && mode[MULTIFRAME_REFRAME_REQUEST_BIT] |=> !mf_reframe_o)
		else $error("multiframe reframe while request held");
	chk_rem_modify: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && transparent && mode[REMAINDER_MODIFY_ENABLE_BIT]
		|=> crc_rem_o == $past(rx_crc_rem_i ^ tx_crc_delta_i))
		else $error("remainder not modified");
	chk_rem_pass: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && !(transparent && mode[REMAINDER_MODIFY_ENABLE_BIT])
		|=> crc_rem_o == $past(rx_crc_rem_i))
		else $error("remainder altered");
	chk_intl_bits_nfas: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && mode[CRC4_SYNC_DISABLE_BIT] && !frame_is_fas_i
		|=> ts0_bit1_o == $past(slot0[INTL_BIT_NFAS_BIT]))
		else $error("second international bit not sent");
	chk_intl_override: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && !mode[CRC4_SYNC_DISABLE_BIT] |=> ts0_bit1_o == $past(framed_bit_i))
		else $error("international bits not overridden");
	chk_line_ts0_slot: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		ce_i && !transparent && ts0_bit1_slot_i && mode[CRC4_SYNC_DISABLE_BIT] && frame_is_fas_i
		|=> tx_line_bit_o == $past(slot0[INTL_BIT_FAS_BIT]))
		else $error("international bit missing from line");

endmodule

/* File: pkg/e1msc_ais_if.sv */
interface e1msc_ais_if;
	logic bit_valid;
	logic bit_data;
	logic two_window;
	logic ais;

	modport ctrl (output bit_valid, output bit_data, output two_window, input ais);
	modport det  (input bit_valid, input bit_data, input two_window, output ais);
endinterface

/* File: pkg/e1msc_pkg.sv */
package e1msc_pkg;

	// ****************************************
	// Register map, page 1
	// ****************************************
	localparam logic [4:0] MODE_SELECT_CTRL       = 5'h10;
	localparam logic [4:0] TX_ALARM_CTRL          = 5'h11;
	localparam logic [4:0] SLOT_ZERO_CTRL         = 5'h12;
	localparam logic [4:0] TX_MULTIFRAME_ALIGN    = 5'h13;
	localparam logic [4:0] IRQ_SIGNALING_CTRL     = 5'h14;
	localparam logic [4:0] CODING_LOOPBACK_CTRL   = 5'h15;
	localparam logic [4:0] NON_FRAME_ALIGN_CTRL   = 5'h16;
	localparam logic [4:0] MULTIFRAME_LINK_SELECT = 5'h17;
	localparam logic [4:0] TX_MESSAGE             = 5'h18;
	localparam logic [4:0] ERROR_INSERT           = 5'h19;
	localparam logic [4:0] SIGNALING_CTRL         = 5'h1a;
	localparam logic [4:0] IRQ_MASK_0             = 5'h1b;
	localparam logic [4:0] IRQ_MASK_1             = 5'h1c;
	localparam logic [4:0] IRQ_MASK_2             = 5'h1d;
	localparam logic [4:0] IRQ_MASK_3             = 5'h1e;
	localparam logic [4:0] LINE_RECEIVER_CTRL     = 5'h1f;
	localparam logic [4:0] CTRL_BASE              = 5'h10;
	localparam int         CTRL_WORDS             = 16;
	localparam logic [7:0] CTRL_RESET             = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int ALARM_CRITERION_SELECT_BIT     = 7;
	localparam int REMAINDER_MODIFY_ENABLE_BIT    = 6;
	localparam int AUTO_INTERWORK_DISABLE_BIT     = 5;
	localparam int MANUAL_REMOTE_ALARM_BIT        = 4;
	localparam int MANUAL_Y_BIT_BIT               = 3;
	localparam int CRC4_SYNC_DISABLE_BIT          = 2;
	localparam int BASIC_REFRAME_REQUEST_BIT      = 1;
	localparam int MULTIFRAME_REFRAME_REQUEST_BIT = 0;
	localparam int TX_TRANSPARENT_MODE_BIT        = 2;
	localparam int INTL_BIT_NFAS_BIT              = 1;
	localparam int INTL_BIT_FAS_BIT               = 0;
	localparam int TX_REMOTE_ALARM_BIT_BIT        = 7;
	localparam int Y_BIT_POS                      = 5;

	// ****************************************
	// Alarm detection
	// ****************************************
	localparam int          AIS_WINDOW_BITS = 512;
	localparam logic [8:0]  AIS_WINDOW_LAST = 9'h1ff;
	localparam logic [1:0]  AIS_ZERO_LIMIT  = 2'h3;

endpackage

/* File: test/e1msc_line_far.sv */
module e1msc_line_far (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic [9:0] zeros_i,
	output logic            rx_bit_valid_o,
	output logic            rx_bit_o,
	output logic            win_last_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Remote terminal line stream
	// ****************************************
	logic [8:0] cnt;
	logic [9:0] zeros;
	logic [9:0] next_zeros;

	// The zero count is taken only at a window start, so a request never splits a window.
	assign next_zeros = (cnt == 9'h000) ? zeros_i : zeros;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt            <= 9'h000;
			zeros          <= 10'h000;
			rx_bit_valid_o <= 1'b0;
			rx_bit_o       <= 1'b1;
			win_last_o     <= 1'b0;
		end else begin
			cnt            <= cnt + 9'h001;
			zeros          <= next_zeros;
			rx_bit_valid_o <= 1'b1;
			rx_bit_o       <= ({1'b0, cnt} >= next_zeros);
			win_last_o     <= (cnt == 9'h1ff);
		end
	end
endmodule

/* File: test/tb_top.sv */
module tb_top
	import e1msc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Stimulus and scoreboard state
	// ****************************************
	typedef struct {int due; int sel; logic [7:0] val;} e1msc_note_s;
	// A reframe request must stand a frame; a short frame keeps the run brief.
	localparam int FRAME_CYC = 16;
	e1msc_note_s q[$];
	logic clk = 1'b0, arst_n = 1'b0, cs = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdata = 8'h00, rdata, m, t, mf, nf;
	logic bsync = 0, mfsync = 0, fas = 0, slot = 0, framed = 0, ser = 0, ts;
	logic [3:0] rem = 4'h0, dlt = 4'h0, crem;
	logic lbit, alm, ybit, ts0b, c4en, iwen, ais, brf, mrf, rxv, rxb, wlast;
	logic [9:0] zreq = 10'h000;
	logic [7:0] img [16];
	int cyc = 0, n_errors = 0, num_checks = 0, tmo = 0;
	int az [7] = '{0, 2, 3, 2, 3, 2, 0};
	logic ae [7] = '{1, 1, 0, 1, 0, 0, 1};

	e1msc_ctrl u_e1msc_ctrl (.clk_i(clk), .arst_n_i(arst_n), .ce_i(1'b1), .cs_i(cs),
		.wr_i(wr), .rd_i(rd), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
		.rx_bit_valid_i(rxv), .rx_bit_i(rxb), .basic_sync_i(bsync), .mf_sync_i(mfsync),
		.frame_is_fas_i(fas), .ts0_bit1_slot_i(slot), .framed_bit_i(framed),
		.tx_serial_stream_in_i(ser), .rx_crc_rem_i(rem), .tx_crc_delta_i(dlt),
		.crc_rem_o(crem), .tx_line_bit_o(lbit), .tx_remote_alarm_o(alm), .tx_y_bit_o(ybit),
		.ts0_bit1_o(ts0b), .crc4_sync_en_o(c4en), .auto_interwork_en_o(iwen),
		.ais_o(ais), .basic_reframe_o(brf), .mf_reframe_o(mrf));
	e1msc_line_far u_e1msc_line_far (.clk_i(clk), .arst_n_i(arst_n), .zeros_i(zreq),
		.rx_bit_valid_o(rxv), .rx_bit_o(rxb), .win_last_o(wlast));

	always #4 clk = ~clk;

	function automatic logic [7:0] obs(int s);
		case (s)
			0: return rdata;
			1: return {4'h0, crem};
			2: return {7'h00, lbit};
			3: return {7'h00, alm};
			4: return {7'h00, ybit};
			5: return {7'h00, ts0b};
			6: return {7'h00, c4en};
			7: return {7'h00, iwen};
			8: return {7'h00, ais};
			9: return {7'h00, brf};
			default: return {7'h00, mrf};
		endcase
	endfunction

	// ****************************************
	// Output watcher and run control
	// ****************************************
	always @(negedge clk) begin
		cyc++;
		while (q.size() > 0 && q[0].due <= cyc) begin
			num_checks++;
			if (obs(q[0].sel) !== q[0].val) begin
				n_errors++;
				$display("mismatch t=%0t sel=%0d exp=%h got=%h", $time, q[0].sel, q[0].val,
					obs(q[0].sel));
			end
			void'(q.pop_front());
		end
	end

	always @(posedge clk) begin
		tmo++;
		if (tmo == 25000) begin
			n_errors++;
			results();
		end
	end

	task automatic results();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic note(int d, int s, logic [7:0] v);
		q.push_back('{cyc + d, s, v});
	endtask

	task automatic wreg(logic [4:0] a, logic [7:0] d);
		@(posedge clk);
		cs <= 1'b1;
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		cs <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rreg(logic [4:0] a, logic [7:0] e);
		@(posedge clk);
		cs <= 1'b1;
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		cs <= 1'b0;
		rd <= 1'b0;
		note(1, 0, e);
	endtask

	// The request goes in one window early so that the checked window holds it whole.
	task automatic ais_win(int z, logic e);
		zreq <= 10'(z);
		repeat (2) @(posedge clk iff wlast);
		note(6, 8, {7'h00, e});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(4));
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 16; i++)
			rreg(5'(CTRL_BASE + i), CTRL_RESET);
		for (int i = 0; i < 16; i++) begin
			img[i] = 8'($urandom);
			wreg(5'(CTRL_BASE + i), img[i]);
		end
		wreg(5'h03, 8'hff);
		for (int i = 0; i < 16; i++)
			rreg(5'(CTRL_BASE + i), img[i]);
		rreg(5'h03, 8'h00);
		for (int b = 0; b < 2; b++) begin
			wreg(MODE_SELECT_CTRL, 8'(2 >> b));
			repeat (FRAME_CYC) @(posedge clk);
			wreg(MODE_SELECT_CTRL, 8'h00);
			note(1, 9 + b, 8'h00);
			note(2, 9 + b, 8'h01);
			note(2, 10 - b, 8'h00);
			note(3, 9 + b, 8'h00);
			repeat (4) @(posedge clk);
		end
		for (int k = 0; k < 24; k++) begin
			m = 8'($urandom) & 8'hfc;
			t = 8'($urandom);
			mf = 8'($urandom);
			nf = 8'($urandom);
			wreg(MODE_SELECT_CTRL, m);
			wreg(SLOT_ZERO_CTRL, t);
			wreg(TX_MULTIFRAME_ALIGN, mf);
			wreg(NON_FRAME_ALIGN_CTRL, nf);
			{bsync, mfsync, fas, slot, framed, ser, rem, dlt} <= 14'($urandom);
			@(posedge clk);
			ts = m[2] ? (fas ? t[0] : t[1]) : framed;
			note(2, 1, {4'h0, (t[2] & m[6]) ? rem ^ dlt : rem});
			note(2, 2, {7'h00, t[2] ? ser : (slot ? ts : framed)});
			note(2, 3, {7'h00, m[4] ? nf[7] : bsync});
			note(2, 4, {7'h00, m[3] ? mf[5] : ~mfsync});
			note(2, 5, {7'h00, ts});
			note(2, 6, {7'h00, ~m[2]});
			note(2, 7, {7'h00, ~m[5]});
			repeat (3) @(posedge clk);
		end
		wreg(MODE_SELECT_CTRL, 8'h00);
		for (int i = 0; i < 7; i++) begin
			if (i == 4)
				wreg(MODE_SELECT_CTRL, 8'h80);
			ais_win(az[i], ae[i]);
		end
		repeat (8) @(posedge clk);
		results();
	end
endmodule
